/* File: frac_n_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - a load carries exactly 32 bits
// - one bit per serial clock while selected
// - the two moduli are P and P-1
// - select output picks P or P-1
// - integer ratio holds select on P
// - pattern holds the programmed counts
// - every reference edge used, offsets cancel
// - rational ratios from P-1 to P with denominator at most 31
// - gate blocks both pump pulses
// - phase difference goes to lock logic
// - pump 20uA, then 50uA after trim
// - P is 17 plus modulus select
// - counts are 5-bit, sum at most 31
// - one zero count gives pure P or P-1
// - accumulator adds lower count, modulo sum
module frac_n_ctrl
(
  input  wire logic        i_clk,          // reference clock
  input  wire logic        i_resetn,       // async reset, active low
  input  wire logic        i_sclk,         // serial clock pin
  input  wire logic        i_cs,           // chip select pin
  input  wire logic        i_sdi,          // serial data pin
  input  wire logic        i_trim_done,    // trim finished, level
  input  wire logic        i_pump_up_raw,  // detector pump up
  input  wire logic        i_pump_dn_raw,  // detector pump down
  output logic [5:0]       o_modulus,      // P
  output logic [5:0]       o_modulus_m1,   // P-1
  output logic             o_sel_p,        // 1: divide by P
  output logic             o_pfd_gate,     // 1: block pumps
  output logic             o_pump_up,      // gated pump up
  output logic             o_pump_dn,      // gated pump down
  output logic             o_phase_err,    // phase difference
  output logic             o_cp_high,      // 1: high current
  output logic [5:0]       o_cp_ua,        // pump current, uA
  output logic [17:0]      o_wrapper_cfg,  // wrapper settings
  output logic             o_cfg_valid,    // usable counts applied
  output logic             o_cfg_error     // last frame refused
);

  // ---------------------------------------------------------------
  // serial capture on the link clock
  // ---------------------------------------------------------------
  logic [frac_n_pkg::CFG_BITS-1:0] shift_word;

  cfg_shift_in u_shift
  (
    .i_sclk   (i_sclk),
    .i_resetn (i_resetn),
    .i_cs     (i_cs),
    .i_sdi    (i_sdi),
    .o_word   (shift_word)
  );

  // ---------------------------------------------------------------
  // synchronisers for pins
  // ---------------------------------------------------------------
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_d_reg;
  logic sclk_meta_reg;
  logic sclk_sync_reg;
  logic sclk_d_reg;
  logic trim_meta_reg;
  logic trim_sync_reg;

  // two flops each; the slow serial clock is sampled as data
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cs_meta_reg   <= 1'b0;
      cs_sync_reg   <= 1'b0;
      cs_d_reg      <= 1'b0;
      sclk_meta_reg <= 1'b0;
      sclk_sync_reg <= 1'b0;
      sclk_d_reg    <= 1'b0;
      trim_meta_reg <= 1'b0;
      trim_sync_reg <= 1'b0;
    end
    else
    begin
      cs_meta_reg   <= i_cs;
      cs_sync_reg   <= cs_meta_reg;
      cs_d_reg      <= cs_sync_reg;
      sclk_meta_reg <= i_sclk;
      sclk_sync_reg <= sclk_meta_reg;
      sclk_d_reg    <= sclk_sync_reg;
      trim_meta_reg <= i_trim_done;
      trim_sync_reg <= trim_meta_reg;
    end
  end

  // edges; a serial clock of 2MHz or less leaves each level
  // standing for at least one sample, so no edge is missed
  wire cs_rise   = cs_sync_reg & ~cs_d_reg;
  wire cs_fall   = ~cs_sync_reg & cs_d_reg;
  wire sclk_rise = sclk_sync_reg & ~sclk_d_reg & cs_sync_reg;

  // ---------------------------------------------------------------
  // frame length and decode
  // ---------------------------------------------------------------
  logic [5:0] bit_cnt_reg;
  logic [5:0] bit_cnt_next;

  // counts serial clocks inside the select; saturates so that a
  // long frame can never wrap back onto the legal length
  assign bit_cnt_next = cs_rise ? 6'h00 :
                        (sclk_rise && bit_cnt_reg != frac_n_pkg::CNT_SAT)
                        ? bit_cnt_reg + 6'h01 : bit_cnt_reg;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      bit_cnt_reg <= 6'h00;
    else
      bit_cnt_reg <= bit_cnt_next;
  end

  // the shifted word is only taken at cs_fall, long after the
  // last serial edge, so it is still when it is sampled here
  frac_n_pkg::cfg_t frame_cfg;
  assign frame_cfg = frac_n_pkg::cfg_t'(shift_word);

  wire [5:0] frame_total  = {1'b0, frame_cfg.upper_count}
                          + {1'b0, frame_cfg.lower_count};
  wire frame_len_ok = (bit_cnt_reg == frac_n_pkg::FRAME_BITS);
  wire frame_sum_ok = (frame_total <= frac_n_pkg::COUNT_MAX);
  wire load_pulse   = cs_fall & frame_len_ok & frame_sum_ok;
  wire reject_pulse = cs_fall & ~(frame_len_ok & frame_sum_ok);

  // ---------------------------------------------------------------
  // applied settings
  // ---------------------------------------------------------------
  frac_n_pkg::cfg_t cfg_reg;
  logic             cfg_valid_reg;
  logic             cfg_error_reg;
  logic [5:0]       p_reg;
  logic [5:0]       pm1_reg;

  wire [5:0] frame_p = frac_n_pkg::P_BASE
                     + {2'b00, frame_cfg.modulus_select};

  // settings change only on a whole, legal frame; a refused one
  // leaves the running pattern untouched
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cfg_reg       <= '0;
      cfg_valid_reg <= 1'b0;
      p_reg         <= frac_n_pkg::P_BASE;
      pm1_reg       <= frac_n_pkg::P_BASE - frac_n_pkg::P_STEP;
    end
    else if (load_pulse)
    begin
      cfg_reg       <= frame_cfg;
      cfg_valid_reg <= (frame_total != 6'h00);
      p_reg         <= frame_p;
      pm1_reg       <= frame_p - frac_n_pkg::P_STEP;
    end
  end

  // error follows the latest frame end
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      cfg_error_reg <= 1'b0;
    else if (reject_pulse)
      cfg_error_reg <= 1'b1;
    else if (load_pulse)
      cfg_error_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // pattern accumulator, one step per reference period
  // ---------------------------------------------------------------
  logic [4:0] acc_reg;
  logic       sel_reg;
  logic       gate_reg;

  wire [5:0] total   = {1'b0, cfg_reg.upper_count}
                     + {1'b0, cfg_reg.lower_count};
  wire [5:0] acc_sum = {1'b0, acc_reg} + {1'b0, cfg_reg.lower_count};
  wire       acc_wrap = (acc_sum >= total);
  wire [5:0] acc_mod  = acc_wrap ? acc_sum - total : acc_sum;
  wire       hold     = load_pulse | ~cfg_valid_reg;

  // spreading the P-1 periods evenly keeps each chosen feedback
  // edge nearest its reference edge; the sum returns to zero at
  // the end of every pattern, so the offsets cancel
  wire [4:0] acc_next = hold ? 5'h00 : acc_mod[4:0];
  wire       sel_next = hold | ~acc_wrap;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc_reg  <= 5'h00;
      sel_reg  <= 1'b1;
      gate_reg <= 1'b1;
    end
    else
    begin
      acc_reg  <= acc_next;
      sel_reg  <= sel_next;
      gate_reg <= hold;
    end
  end

  // ---------------------------------------------------------------
  // detector gating and pump current
  // ---------------------------------------------------------------
  logic       cp_high_reg;
  logic [5:0] cp_ua_reg;

  // gated while no usable counts stand and in the restart period,
  // so a half-applied setting never steers the loop
  assign o_pump_up   = i_pump_up_raw & ~gate_reg;
  assign o_pump_dn   = i_pump_dn_raw & ~gate_reg;
  assign o_phase_err = i_pump_up_raw | i_pump_dn_raw;

  // low current until trimming ends, higher gain afterwards
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cp_high_reg <= 1'b0;
      cp_ua_reg   <= frac_n_pkg::CP_LOW_UA;
    end
    else
    begin
      cp_high_reg <= trim_sync_reg;
      cp_ua_reg   <= trim_sync_reg ? frac_n_pkg::CP_HIGH_UA
                                   : frac_n_pkg::CP_LOW_UA;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_modulus     = p_reg;
  assign o_modulus_m1  = pm1_reg;
  assign o_sel_p       = sel_reg;
  assign o_pfd_gate    = gate_reg;
  assign o_cp_high     = cp_high_reg;
  assign o_cp_ua       = cp_ua_reg;
  assign o_wrapper_cfg = cfg_reg.wrapper_cfg;
  assign o_cfg_valid   = cfg_valid_reg;
  assign o_cfg_error   = cfg_error_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // helper: step and ones count over one pattern
  logic [5:0] pos_reg;
  logic [5:0] ones_reg;
  wire        step      = ~hold;
  wire        last_step = step & (pos_reg == total - 6'h01);
  wire [5:0]  ones_now  = ones_reg + {5'h00, ~acc_wrap};

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pos_reg  <= 6'h00;
      ones_reg <= 6'h00;
    end
    else if (!step || last_step)
    begin
      pos_reg  <= 6'h00;
      ones_reg <= 6'h00;
    end
    else
    begin
      pos_reg  <= pos_reg + 6'h01;
      ones_reg <= ones_now;
    end
  end

  sequence s_good_frame_end;
    cs_fall && frame_len_ok && frame_sum_ok;
  endsequence
  sequence s_restart;
    acc_reg == 5'h00 && o_pfd_gate && o_sel_p
    && o_modulus == frac_n_pkg::P_BASE
       + {2'b00, cfg_reg.modulus_select}
    ##1 (!o_pfd_gate || !o_cfg_valid);
  endsequence
  chk_load_restart: assert property (
    s_good_frame_end |=> s_restart)
    else $error("settings not applied with a clean restart");
  chk_frame_length: assert property (
    cs_fall && !frame_len_ok |=> o_cfg_error && $stable(o_modulus)
                                 && $stable(o_wrapper_cfg))
    else $error("frame of wrong length changed the settings");
  chk_modulus_pair: assert property (
    o_modulus_m1 + frac_n_pkg::P_STEP == o_modulus)
    else $error("moduli do not differ by one");
  chk_modulus_decode: assert property (
    o_modulus == frac_n_pkg::P_BASE + {2'b00, cfg_reg.modulus_select})
    else $error("modulus does not match its select");
  chk_integer_hold: assert property (
    o_cfg_valid && cfg_reg.lower_count == 5'h00 && !load_pulse
    |=> o_sel_p [*2])
    else $error("integer ratio left the P divider");
  chk_lower_only: assert property (
    o_cfg_valid && cfg_reg.upper_count == 5'h00 && !load_pulse
    |=> !o_sel_p)
    else $error("zero upper count still selected P");
  chk_pattern_mix: assert property (
    last_step |-> ones_now == {1'b0, cfg_reg.upper_count})
    else $error("pattern does not hold the programmed count of P");
  chk_offset_cancel: assert property (
    last_step |=> acc_reg == 5'h00)
    else $error("accumulator not back at zero after the pattern");
  chk_accum_range: assert property (
    o_cfg_valid |-> {1'b0, acc_reg} < total)
    else $error("accumulator outside the modulo range");
  chk_sum_limit: assert property (
    o_cfg_valid |-> total <= frac_n_pkg::COUNT_MAX)
    else $error("applied counts exceed their limit");
  chk_gate_pumps: assert property (
    o_pfd_gate |-> !o_pump_up && !o_pump_dn)
    else $error("pump pulse passed while gated");
  chk_cp_switch: assert property (
    $rose(trim_sync_reg) |=> o_cp_high
                             && o_cp_ua == frac_n_pkg::CP_HIGH_UA)
    else $error("pump current did not rise after trim");

endmodule

/* File: frac_n_pkg.sv */
package frac_n_pkg;

  // ---------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------
  localparam int         CFG_BITS   = 32;
  localparam logic [5:0] FRAME_BITS = 6'h20;  // bits in one load
  localparam logic [5:0] CNT_SAT    = 6'h3f;  // bit counter ceiling

  // ---------------------------------------------------------------
  // divider settings
  // ---------------------------------------------------------------
  localparam int         CNT_W     = 5;       // period count width
  localparam int         MSEL_W    = 4;       // modulus select width
  localparam int         AUX_W     = 18;      // wrapper settings
  localparam logic [5:0] P_BASE    = 6'h11;   // P for select 0 (17)
  localparam logic [5:0] P_STEP    = 6'h01;   // P and P-1 differ by one
  localparam logic [5:0] COUNT_MAX = 6'h1f;   // ceiling of count sum

  // ---------------------------------------------------------------
  // charge pump current in microamps
  // ---------------------------------------------------------------
  localparam logic [5:0] CP_LOW_UA  = 6'h14;  // 20 uA, acquisition
  localparam logic [5:0] CP_HIGH_UA = 6'h32;  // 50 uA, after trim

  // one configuration word, first bit shifted in is bit 31
  typedef struct packed {
    logic [AUX_W-1:0]  wrapper_cfg;
    logic [CNT_W-1:0]  lower_count;
    logic [CNT_W-1:0]  upper_count;
    logic [MSEL_W-1:0] modulus_select;
  } cfg_t;

endpackage

/* File: cfg_shift_in.sv */
`timescale 1ns/1ps
module cfg_shift_in
(
  input  wire logic        i_sclk,    // serial clock from host
  input  wire logic        i_resetn,  // async reset, active low
  input  wire logic        i_cs,      // chip select, active high
  input  wire logic        i_sdi,     // serial data
  output logic [31:0]      o_word     // last bits shifted in
);

  // ---------------------------------------------------------------
  // shift register on the serial clock
  // ---------------------------------------------------------------
  logic [31:0] word_reg;
  logic [31:0] word_next;

  // one bit per serial clock while selected; msb arrives first
  assign word_next = i_cs ? {word_reg[30:0], i_sdi} : word_reg;

  // the word stays still once the clock stops, which the other
  // domain relies on when it takes the word after select falls
  always_ff @(posedge i_sclk or negedge i_resetn)
  begin
    if (!i_resetn)
      word_reg <= 32'h0000_0000;
    else
      word_reg <= word_next;
  end

  assign o_word = word_reg;

endmodule

/* File: frac_host.sv */
`timescale 1ns/1ps
module frac_host
(
  output logic o_sclk,  // serial clock to device
  output logic o_cs,    // chip select, active high
  output logic o_sdi    // serial data to device
);
  logic hclk;  // host timebase, 12 ns, free of the reference phase

  initial
  begin
    hclk   = 1'b0;
    o_sclk = 1'b0;
    o_cs   = 1'b0;
    o_sdi  = 1'b0;
  end

  always #6 hclk = ~hclk;

  // ---------------------------------------------------------------
  // one frame, msb first; halves of 252 ns keep the clock under 2 MHz
  // ---------------------------------------------------------------
  task automatic send(input logic [31:0] w, input int n);
    int i;
    repeat (16) @(posedge hclk);  // idle gap between frames
    o_cs <= 1'b1;
    repeat (9) @(posedge hclk);  // select leads first data by 108 ns
    for (i = 0; i < n; i++)
    begin
      o_sdi <= (i < 32) ? w[31 - i] : 1'b1;
      repeat (21) @(posedge hclk);
      o_sclk <= 1'b1;
      repeat (21) @(posedge hclk);
      o_sclk <= 1'b0;
    end
    repeat (9) @(posedge hclk);
    o_cs  <= 1'b0;
    o_sdi <= ~o_sdi;  // released line must not show the stale bit
  endtask
endmodule

/* File: fractional_n_divider_control_test.sv */
`timescale 1ns/1ps
module fractional_n_divider_control_test;
  logic        i_clk, i_resetn, i_trim_done, i_pump_up_raw, i_pump_dn_raw;
  wire logic   sclk, cs, sdi;
  logic [5:0]  o_modulus, o_modulus_m1, o_cp_ua, last_p;
  logic        o_sel_p, o_pfd_gate, o_pump_up, o_pump_dn, o_phase_err;
  logic        o_cp_high, o_cfg_valid, o_cfg_error;
  logic [17:0] o_wrapper_cfg;
  int          errors, cmp_count, cycles;

  frac_n_ctrl u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk),
    .i_cs(cs), .i_sdi(sdi), .i_trim_done(i_trim_done),
    .i_pump_up_raw(i_pump_up_raw), .i_pump_dn_raw(i_pump_dn_raw),
    .o_modulus(o_modulus), .o_modulus_m1(o_modulus_m1), .o_sel_p(o_sel_p),
    .o_pfd_gate(o_pfd_gate), .o_pump_up(o_pump_up), .o_pump_dn(o_pump_dn),
    .o_phase_err(o_phase_err), .o_cp_high(o_cp_high), .o_cp_ua(o_cp_ua),
    .o_wrapper_cfg(o_wrapper_cfg), .o_cfg_valid(o_cfg_valid),
    .o_cfg_error(o_cfg_error));

  frac_host u_host (.o_sclk(sclk), .o_cs(cs), .o_sdi(sdi));

  initial
  begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_trim_done = 1'b0;
    i_pump_up_raw = 1'b0;
    i_pump_dn_raw = 1'b0;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    last_p = frac_n_pkg::P_BASE;
  end

  always #20 i_clk = ~i_clk;

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // sample just after the edge so its updates have landed
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask

  task automatic stop_test;
    if (errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    tick;
    check(o_modulus, 6'h11);
    check(o_modulus_m1, 6'h10);
    check({o_sel_p, o_pfd_gate, o_cfg_valid, o_cfg_error}, 4'hc);
    check({o_cp_high, o_cp_ua}, {1'b0, frac_n_pkg::CP_LOW_UA});
  endtask

  // trim level reaches the pump setting after the sync stages
  task automatic t_trim(input logic lvl, input logic [5:0] ua);
    @(posedge i_clk);
    i_trim_done <= lvl;
    tick;
    check(o_cp_high, !lvl);
    repeat (3) tick;
    check({o_cp_high, o_cp_ua}, {lvl, ua});
  endtask

  task automatic t_load(input logic [3:0] code, input logic [4:0] up,
                        input logic [4:0] lo, input logic [17:0] wr);
    int i, k, acc, tot;
    u_host.send({wr, lo, up, code}, 32);
    for (k = 0; k < 20 && o_pfd_gate !== 1'b1; k++)
      tick;
    for (k = 0; k < 5 && o_pfd_gate !== 1'b0; k++)
      tick;
    last_p = frac_n_pkg::P_BASE + 6'(code);
    check(o_pfd_gate, 1'b0);
    check(o_modulus, last_p);
    check(o_modulus_m1, last_p - frac_n_pkg::P_STEP);
    check({o_wrapper_cfg, o_cfg_valid, o_cfg_error}, {wr, 2'b10});
    acc = 0;
    tot = int'(up) + int'(lo);
    // two whole periods of the pattern, from a fresh accumulator
    for (i = 0; i < 2 * tot; i++)
    begin
      if (i > 0)
        tick;
      acc += int'(lo);
      check(o_sel_p, acc < tot);
      if (acc >= tot)
        acc -= tot;
    end
  endtask

  // wrong length or oversize sum keeps the old settings
  task automatic t_refused(input int n, input logic [4:0] up,
                           input logic [4:0] lo);
    u_host.send({18'h00000, lo, up, 4'h5}, n);
    repeat (8) tick;
    check({o_cfg_error, o_modulus}, {1'b1, last_p});
  endtask

  task automatic t_zero;
    int k;
    u_host.send({18'h00000, 5'h00, 5'h00, 4'h2}, 32);
    repeat (8) tick;
    check(o_cfg_error, 1'b0);
    check(o_modulus, 6'h13);
    for (k = 0; k < 6; k++)
    begin
      check({o_pfd_gate, o_sel_p, o_cfg_valid}, 3'h6);
      tick;
    end
  endtask

  // detector pulses pass only while ungated; lock path sees them always
  task automatic t_pumps(input logic gated);
    int k;
    for (k = 0; k < 4; k++)
    begin
      @(posedge i_clk);
      i_pump_up_raw <= k[1];
      i_pump_dn_raw <= k[0];
      tick;
      check(o_pump_up, k[1] & !gated);
      check(o_pump_dn, k[0] & !gated);
      check(o_phase_err, k[1] | k[0]);
    end
    @(posedge i_clk);
    i_pump_up_raw <= 1'b0;
    i_pump_dn_raw <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // watchdog: whole run is about 10200 reference cycles
  // ---------------------------------------------------------------
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 15000)
    begin
      errors++;
      stop_test;
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int c;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset_values;
    t_pumps(1'b1);
    t_trim(1'b1, frac_n_pkg::CP_HIGH_UA);
    t_trim(1'b0, frac_n_pkg::CP_LOW_UA);
    // every modulus code; the ends give pure P-1 and pure P
    for (c = 0; c < 16; c++)
      t_load(4'(c), 5'(c), 5'(15 - c), {14'h2a5a, 4'(c)});
    t_load(4'h3, 5'h12, 5'h05, 18'h3fffe);
    t_load(4'h9, 5'h10, 5'h0f, 18'h00001);
    t_pumps(1'b0);
    t_refused(31, 5'h02, 5'h01);
    t_refused(33, 5'h02, 5'h01);
    t_refused(32, 5'h14, 5'h0c);
    t_zero;
    t_pumps(1'b1);
    t_load(4'h0, 5'h02, 5'h01, 18'h15555);
    stop_test;
  end
endmodule
